// ---- plb_params.svh ----
// register map, field positions, reset values and counts for the self-test block
`ifndef PLB_PARAMS_SVH
`define PLB_PARAMS_SVH
`define PLB_ADR_BMC     5'h00
`define PLB_ADR_STC     5'h16
`define PLB_ADR_ERR     5'h1B
`define PLB_ADR_LEN     5'h1C
`define PLB_BMC_LOOP    14
`define PLB_STC_RUN     15
`define PLB_STC_CONT    14
`define PLB_STC_SINGLE  13
`define PLB_STC_LONG    12
`define PLB_STC_LOCK    11
`define PLB_STC_LOST    10
`define PLB_STC_BUSY    9
`define PLB_STC_MTX     6
`define PLB_STC_REV     4
`define PLB_STC_ANA     3
`define PLB_STC_DIG     2
`define PLB_STC_PCSO    1
`define PLB_STC_PCSI    0
`define PLB_STC_WMASK   16'hD05F
`define PLB_BMC_RST     16'h0000
`define PLB_STC_RST     16'h0000
`define PLB_LEN_RST     16'h6040
`define PLB_LEN_HI      10
`define PLB_GAP_LO      11
`define PLB_GAP_HI      15
`define PLB_SHORT_BYTES 11'h040
`define PLB_LONG_BYTES  11'h5EE
`define PLB_FILL_NIB    4'h5
`define PLB_SEED        15'h7FFF
`define PLB_TAP_A       14
`define PLB_TAP_B       13
`define PLB_OP_RD       2'h2
`define PLB_OP_WR       2'h1
`define PLB_HDR_LAST    4'hB
`define PLB_DATA_LAST   4'hF
`define PLB_STRAP_TAKE  2'h2
`define PLB_LOCK_NIB    8
`define PLB_LOSS_NIB    8
`endif

// ---- plb_pkg.sv ----
// types and the shared prbs step function of the self-test block
package plb_pkg;
	`include "plb_params.svh"
	typedef struct packed {
		logic       en;
		logic [3:0] d;
	} plb_nib_t;
	typedef struct packed {
		logic pcs_in;
		logic pcs_out;
		logic digital;
		logic analog;
	} plb_lpt_t;
	typedef struct packed {
		logic [1:0] op;
		logic [4:0] phy;
		logic [4:0] adr;
	} plb_hdr_t;
	typedef struct packed {
		logic [14:0] st;
		logic [3:0]  nib;
	} plb_step_t;
	typedef enum logic [1:0] {
		PLB_G_IDLE = 2'h0,
		PLB_G_DATA = 2'h1,
		PLB_G_GAP  = 2'h2
	} plb_gst_t;
	typedef enum logic [1:0] {
		PLB_M_IDLE = 2'h0,
		PLB_M_HDR  = 2'h1,
		PLB_M_TA   = 2'h2,
		PLB_M_DATA = 2'h3
	} plb_mst_t;
	// four serial steps of x^15+x^14+1, msb first; ext feeds received bits
	function automatic plb_step_t plb_lfsr4(input logic [14:0] s,
		input logic [3:0] rx, input logic ext);
		plb_step_t r;
		logic      b;
		r.st  = s;
		r.nib = 4'h0;
		for (int i = 3; i >= 0; i--) begin
			b        = r.st[`PLB_TAP_A] ^ r.st[`PLB_TAP_B];
			r.nib[i] = b;
			r.st     = {r.st[13:0], ext ? rx[i] : b};
		end
		return r;
	endfunction
endpackage

// ---- plb_prbs_gen.sv ----
// self-test packet generator: prbs packets with gaps, or one constant packet
`timescale 1ns/1ps
`include "plb_params.svh"
module plb_prbs_gen (
	input  wire logic             mclk,      // core clock
	input  wire logic             rst,       // async reset, high
	input  wire logic             stb,       // one nibble time
	input  wire logic             run,       // keep sending prbs packets
	input  wire logic             go,        // request one constant packet
	input  wire logic             long_pkt,  // constant packet is long
	input  wire logic [10:0]      len_bytes, // prbs packet length, bytes
	input  wire logic [4:0]       gap_bytes, // inter-packet gap, bytes
	output plb_pkg::plb_nib_t     tx_o,      // generated nibble
	output logic                  busy,      // packet or gap in flight
	output logic                  done       // constant packet finished
);
	plb_pkg::plb_gst_t st_r, st_nxt;
	logic [11:0]       cnt_r, cnt_nxt;
	logic              cst_r, cst_nxt;
	logic [14:0]       lfsr_r;
	logic [10:0]       bytes_w;
	plb_pkg::plb_step_t step_w;
	// lengths in nibbles; a zero gap still leaves one byte of idle
	assign bytes_w = cst_r ? (long_pkt ? `PLB_LONG_BYTES : `PLB_SHORT_BYTES)
		: len_bytes;
	assign step_w  = plb_pkg::plb_lfsr4(lfsr_r, 4'h0, 1'h0);
	// a running stream stays busy through its one idle step between packets
	assign busy    = st_r != plb_pkg::PLB_G_IDLE || run;
	// packet, gap, idle sequencing
	always_comb begin
		st_nxt  = st_r;
		cnt_nxt = cnt_r;
		cst_nxt = cst_r;
		done    = 1'h0;
		case (st_r)
			plb_pkg::PLB_G_IDLE: begin
				// a running stream spends one nibble time here, so gaps stay whole bytes
				if (go || (run && stb)) begin
					st_nxt  = plb_pkg::PLB_G_DATA;
					cnt_nxt = 12'h000;
					cst_nxt = go;
				end
			end
			plb_pkg::PLB_G_DATA: if (stb) begin
				cnt_nxt = cnt_r + 12'h001;
				if (cnt_r == {bytes_w, 1'h0} - 12'h001) begin
					st_nxt  = plb_pkg::PLB_G_GAP;
					cnt_nxt = 12'h000;
				end
			end
			plb_pkg::PLB_G_GAP: if (stb) begin
				cnt_nxt = cnt_r + 12'h001;
				if (cnt_r >= {6'h00, gap_bytes, 1'h0}) begin
					st_nxt = plb_pkg::PLB_G_IDLE;
					done   = cst_r;
				end
			end
			default: st_nxt = plb_pkg::PLB_G_IDLE;
		endcase
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_r   <= plb_pkg::PLB_G_IDLE;
			cnt_r  <= 12'h000;
			cst_r  <= 1'h0;
			lfsr_r <= `PLB_SEED;
			tx_o   <= '0;
		end else begin
			st_r  <= st_nxt;
			cnt_r <= cnt_nxt;
			cst_r <= cst_nxt;
			if (stb) begin
				tx_o.en <= st_r == plb_pkg::PLB_G_DATA;
				tx_o.d  <= cst_r ? `PLB_FILL_NIB : step_w.nib;
			end
			// the sequence only advances on data, so packets join into one stream
			if (stb && st_r == plb_pkg::PLB_G_DATA && !cst_r)
				lfsr_r <= step_w.st;
		end
	end
endmodule // plb_prbs_gen

// ---- plb_prbs_chk.sv ----
// self-synchronising prbs checker with lock, sync loss and error bytes
`timescale 1ns/1ps
`include "plb_params.svh"
module plb_prbs_chk #(
	parameter int ERR_W = 16,            // error counter width
	parameter int LOCK  = `PLB_LOCK_NIB, // good nibbles to lock
	parameter int LOSS  = `PLB_LOSS_NIB  // bad nibbles to lose sync
) (
	input  wire logic             mclk,   // core clock
	input  wire logic             rst,    // async reset, high
	input  wire logic             stb,    // one nibble time
	input  wire logic             clr,    // test start, clears state
	input  wire logic             cont,   // wrap instead of saturate
	input  wire plb_pkg::plb_nib_t rx,    // received nibble
	output logic                  locked, // following the stream
	output logic                  lost,   // lock was lost
	output logic [ERR_W-1:0]      err_cnt // error bytes
);
	logic [14:0]        st_r;
	logic [3:0]         run_r;
	logic               half_r, bad_r, lock_r, lost_r;
	logic               take_w, hit_w, inc_w, sat_w;
	plb_pkg::plb_step_t step_w;
	if (LOCK < 1 || LOCK > 15 || LOSS < 1 || LOSS > 15) begin : g_chk
		$error("lock and loss counts must lie in 1..15");
	end
	// unlocked: seed from the line; locked: free-run and compare
	assign step_w = plb_pkg::plb_lfsr4(st_r, rx.d, !lock_r);
	assign take_w = stb && rx.en;
	assign hit_w  = step_w.nib == rx.d;
	assign sat_w  = &err_cnt;
	// a byte counts once even if both nibbles are wrong
	assign inc_w  = take_w && half_r && (bad_r || !hit_w) && lock_r
		&& !(sat_w && !cont);
	assign locked = lock_r;
	assign lost   = lost_r;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_r    <= `PLB_SEED;
			run_r   <= 4'h0;
			half_r  <= 1'h0;
			bad_r   <= 1'h0;
			lock_r  <= 1'h0;
			lost_r  <= 1'h0;
			err_cnt <= '0;
		end else if (clr) begin
			run_r   <= 4'h0;
			half_r  <= 1'h0;
			lock_r  <= 1'h0;
			lost_r  <= 1'h0;
			err_cnt <= '0;
		end else begin
			if (take_w) begin
				st_r   <= step_w.st;
				half_r <= !half_r;
				bad_r  <= !hit_w;
				run_r  <= (hit_w ^ lock_r) ? run_r + 4'h1 : 4'h0;
			end else if (stb) begin
				half_r <= 1'h0; // pairing restarts with each packet
			end
			if (take_w && !lock_r && hit_w && run_r == 4'(LOCK - 1)) begin
				lock_r <= 1'h1;
				lost_r <= 1'h0;
				run_r  <= 4'h0; // count afresh in the new state
			end
			if (take_w && lock_r && !hit_w && run_r == 4'(LOSS - 1)) begin
				lock_r <= 1'h0;
				lost_r <= 1'h1;
				run_r  <= 4'h0;
			end
			if (inc_w)
				err_cnt <= err_cnt + 1'h1;
		end
	end
endmodule // plb_prbs_chk

// ---- plb_loopback_bist.sv ----
// loopback point selection, prbs self-test and management register slave
`timescale 1ns/1ps
// Overview of operation
// - Basic mode control bit 14 loops MAC transmit back at the nibble interface.
// - Self-test control bits 0..3 pick PCS input, PCS output, digital, analog loop.
// - MAC-side loop reports no link but returns transmit data to MAC receive.
// - Looped data reaches the media only at 100 Mb/s with control bit 6.
// - External loopback is normal mode with loop select bits 3..0 all zero.
// - Control bit 4 sends received line data straight back to the partner.
// - In reverse loop, received data also goes to MAC; MAC inputs ignored.
// - Generator sends a continuous 15-bit prbs stream; tx and rx independent.
// - Test traffic forms packets and gaps, both lengths set by software.
// - Checker compares received data against its own local prbs register.
// - Errored received bytes are counted and read at register 0x1B.
// - Control register shows checker lock, loss of sync and generator busy.
// - Control bit 14 chooses continuous or single test mode.
// - In continuous mode a full counter wraps to zero and keeps counting.
// - In single mode the error counter stops at its maximum value.
// - Prbs packet length comes from the length register at 0x1C.
// - Control bit 13 sends one constant packet of 64 or 1518 bytes.
// - Registers sit behind a clause 22 serial management slave, 32 x 16.
`include "plb_params.svh"
module plb_loopback_bist #(
	parameter int ERR_W = 16 // error counter width
) (
	input  wire logic              mclk,      // 200 MHz core clock
	input  wire logic              rst,       // async reset, high
	input  wire logic              mdc,       // management clock pin
	input  wire logic              mdio_i,    // management data in
	output logic                   mdio_o,    // management data out
	output logic                   mdio_oe_n, // low while driving mdio
	input  wire logic [4:0]        phy_addr,  // address strap pins
	input  wire logic              nib_stb,   // one nibble time
	input  wire logic              speed100,  // link runs at 100 Mb/s
	input  wire logic              link_ok,   // link from the pma
	input  wire plb_pkg::plb_nib_t mac_tx,    // nibble from the MAC
	input  wire plb_pkg::plb_nib_t pcs_rx,    // nibble from the line
	output plb_pkg::plb_nib_t      mac_rx_o,  // nibble to the MAC
	output plb_pkg::plb_nib_t      pcs_tx_o,  // nibble to the line
	output plb_pkg::plb_lpt_t      lb_pt_o,   // loop point to the pcs
	output logic                   link_up_o  // link reported to software
);
	if (ERR_W < 1 || ERR_W > 16) begin : g_chk
		$error("error counter width must lie in 1..16");
	end
	logic              mdc_s1_r, mdc_s2_r, mdc_s3_r;
	logic              mio_s1_r, mio_s2_r;
	logic [4:0]        adr_s1_r, adr_s2_r, phy_ad_r;
	logic [1:0]        strap_r;
	plb_pkg::plb_mst_t m_st_r, m_st_nxt;
	plb_pkg::plb_hdr_t hdr_r, hdr_nxt;
	logic [3:0]        cnt_r, cnt_nxt;
	logic [15:0]       sh_r, sh_nxt;
	logic              last_r, last_nxt, mo_nxt, moe_n_nxt;
	logic              mdc_rise, rd_hit, wr_fire;
	logic [15:0]       wdat, rd_data, stc_rd;
	logic [15:0]       bmc_r, stc_r, len_r;
	logic              single_r, run_q_r, bist_clr;
	logic              gen_busy, gen_done, chk_lock, chk_lost;
	logic [ERR_W-1:0]  err_cnt;
	logic              mii_lb, rev_lb, med_tx_ok, bist_on;
	plb_pkg::plb_lpt_t lpt_w;
	plb_pkg::plb_nib_t gen_tx, tx_src, mac_rx_nxt, pcs_tx_nxt;

	// pins pass two flops, mdc a third for its edge detect; the first flop feeds only the second
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mdc_s1_r <= 1'h0;
			mdc_s2_r <= 1'h0;
			mdc_s3_r <= 1'h0;
			mio_s1_r <= 1'h1;
			mio_s2_r <= 1'h1;
			adr_s1_r <= 5'h00;
			adr_s2_r <= 5'h00;
		end else begin
			mdc_s1_r <= mdc;
			mdc_s2_r <= mdc_s1_r;
			mdc_s3_r <= mdc_s2_r;
			mio_s1_r <= mdio_i;
			mio_s2_r <= mio_s1_r;
			adr_s1_r <= phy_addr;
			adr_s2_r <= adr_s1_r;
		end
	end

	// straps are caught once, after the synchroniser has filled
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			strap_r  <= 2'h0;
			phy_ad_r <= 5'h00;
		end else if (strap_r != 2'h3) begin
			strap_r <= strap_r + 2'h1;
			if (strap_r == `PLB_STRAP_TAKE)
				phy_ad_r <= adr_s2_r;
		end
	end

	// mdc is slow against mclk, so a delayed edge still meets set-up
	assign mdc_rise = mdc_s2_r && !mdc_s3_r;
	assign rd_hit   = hdr_r.phy == phy_ad_r && hdr_r.op == `PLB_OP_RD;
	assign wdat     = {sh_r[14:0], mio_s2_r};
	assign wr_fire  = mdc_rise && m_st_r == plb_pkg::PLB_M_DATA
		&& cnt_r == `PLB_DATA_LAST && hdr_r.phy == phy_ad_r
		&& hdr_r.op == `PLB_OP_WR;

	// management frame: start 01, op, phy, reg, turnaround, 16 data bits
	always_comb begin
		m_st_nxt  = m_st_r;
		hdr_nxt   = hdr_r;
		cnt_nxt   = cnt_r;
		sh_nxt    = sh_r;
		last_nxt  = last_r;
		mo_nxt    = mdio_o;
		moe_n_nxt = mdio_oe_n;
		if (mdc_rise) begin
			last_nxt = mio_s2_r;
			case (m_st_r)
				plb_pkg::PLB_M_IDLE: begin
					if (!last_r && mio_s2_r) begin
						m_st_nxt = plb_pkg::PLB_M_HDR;
						cnt_nxt  = 4'h0;
					end
				end
				plb_pkg::PLB_M_HDR: begin
					hdr_nxt = plb_pkg::plb_hdr_t'({hdr_r[10:0], mio_s2_r});
					cnt_nxt = cnt_r + 4'h1;
					if (cnt_r == `PLB_HDR_LAST) begin
						m_st_nxt = plb_pkg::PLB_M_TA;
						cnt_nxt  = 4'h0;
					end
				end
				plb_pkg::PLB_M_TA: begin
					cnt_nxt = cnt_r + 4'h1;
					if (cnt_r == 4'h0 && rd_hit) begin
						moe_n_nxt = 1'h0;
						mo_nxt    = 1'h0;
						sh_nxt    = rd_data;
					end
					if (cnt_r != 4'h0) begin
						m_st_nxt = plb_pkg::PLB_M_DATA;
						cnt_nxt  = 4'h0;
						mo_nxt   = sh_r[15];
						sh_nxt   = {sh_r[14:0], 1'h0};
					end
				end
				plb_pkg::PLB_M_DATA: begin
					cnt_nxt = cnt_r + 4'h1;
					mo_nxt  = sh_r[15];
					sh_nxt  = wdat;
					if (cnt_r == `PLB_DATA_LAST) begin
						m_st_nxt  = plb_pkg::PLB_M_IDLE;
						moe_n_nxt = 1'h1;
						last_nxt  = 1'h1; // a trailing 0 must not fake a start
					end
				end
				default: m_st_nxt = plb_pkg::PLB_M_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			m_st_r    <= plb_pkg::PLB_M_IDLE;
			hdr_r     <= '0;
			cnt_r     <= 4'h0;
			sh_r      <= 16'h0000;
			last_r    <= 1'h1;
			mdio_o    <= 1'h1;
			mdio_oe_n <= 1'h1;
		end else begin
			m_st_r    <= m_st_nxt;
			hdr_r     <= hdr_nxt;
			cnt_r     <= cnt_nxt;
			sh_r      <= sh_nxt;
			last_r    <= last_nxt;
			mdio_o    <= mo_nxt;
			mdio_oe_n <= moe_n_nxt;
		end
	end

	// register read decode; unmapped addresses read as zero
	function automatic logic [15:0] reg_rd(input logic [4:0] a);
		case (a)
			`PLB_ADR_BMC: reg_rd = bmc_r;
			`PLB_ADR_STC: reg_rd = stc_rd;
			`PLB_ADR_ERR: reg_rd = 16'(err_cnt);
			`PLB_ADR_LEN: reg_rd = len_r;
			default:      reg_rd = 16'h0000;
		endcase
	endfunction
	assign rd_data = reg_rd(hdr_r.adr);

	// status fields overlay the stored control bits
	always_comb begin
		stc_rd                  = stc_r;
		stc_rd[`PLB_STC_SINGLE] = single_r;
		stc_rd[`PLB_STC_LOCK]   = chk_lock;
		stc_rd[`PLB_STC_LOST]   = chk_lost;
		stc_rd[`PLB_STC_BUSY]   = gen_busy;
	end

	// register writes; the single-packet bit clears itself when sent
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bmc_r    <= `PLB_BMC_RST;
			stc_r    <= `PLB_STC_RST;
			len_r    <= `PLB_LEN_RST;
			single_r <= 1'h0;
			run_q_r  <= 1'h0;
		end else begin
			run_q_r <= stc_r[`PLB_STC_RUN];
			if (wr_fire && hdr_r.adr == `PLB_ADR_BMC)
				bmc_r <= wdat;
			if (wr_fire && hdr_r.adr == `PLB_ADR_STC)
				stc_r <= wdat & `PLB_STC_WMASK;
			if (wr_fire && hdr_r.adr == `PLB_ADR_LEN)
				len_r <= wdat;
			if (wr_fire && hdr_r.adr == `PLB_ADR_STC
				&& wdat[`PLB_STC_SINGLE])
				single_r <= 1'h1;
			else if (gen_done)
				single_r <= 1'h0;
		end
	end

	// fixed loop priority keeps overlapping selects deterministic
	assign mii_lb        = bmc_r[`PLB_BMC_LOOP];
	assign lpt_w.pcs_in  = !mii_lb && stc_r[`PLB_STC_PCSI];
	assign lpt_w.pcs_out = !mii_lb && !stc_r[`PLB_STC_PCSI]
		&& stc_r[`PLB_STC_PCSO];
	assign lpt_w.digital = !mii_lb && !stc_r[`PLB_STC_PCSI]
		&& !stc_r[`PLB_STC_PCSO] && stc_r[`PLB_STC_DIG];
	assign lpt_w.analog  = !mii_lb
		&& stc_r[`PLB_STC_ANA:`PLB_STC_PCSI] == 4'h8;
	// no select set is plain operation, as an external plug loop needs
	assign rev_lb        = !mii_lb && stc_r[`PLB_STC_REV]
		&& stc_r[`PLB_STC_ANA:`PLB_STC_PCSI] == 4'h0;
	assign med_tx_ok     = speed100 && stc_r[`PLB_STC_MTX];
	assign bist_on       = stc_r[`PLB_STC_RUN] || single_r;
	assign bist_clr      = stc_r[`PLB_STC_RUN] && !run_q_r;

	// transmit source, then the loop muxes toward MAC and line
	assign tx_src     = bist_on ? gen_tx : mac_tx;
	assign pcs_tx_nxt = rev_lb ? pcs_rx
		: (mii_lb && !med_tx_ok) ? '0 : tx_src;
	assign mac_rx_nxt = mii_lb ? tx_src : pcs_rx;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mac_rx_o  <= '0;
			pcs_tx_o  <= '0;
			lb_pt_o   <= '0;
			link_up_o <= 1'h0;
		end else begin
			lb_pt_o   <= lpt_w;
			link_up_o <= link_ok && !mii_lb;
			if (nib_stb) begin
				mac_rx_o <= mac_rx_nxt;
				pcs_tx_o <= pcs_tx_nxt;
			end
		end
	end

	// generator and checker run on separate paths
	plb_prbs_gen u_gen (
		.mclk      (mclk),
		.rst       (rst),
		.stb       (nib_stb),
		.run       (stc_r[`PLB_STC_RUN]),
		.go        (single_r),
		.long_pkt  (stc_r[`PLB_STC_LONG]),
		.len_bytes (len_r[`PLB_LEN_HI:0]),
		.gap_bytes (len_r[`PLB_GAP_HI:`PLB_GAP_LO]),
		.tx_o      (gen_tx),
		.busy      (gen_busy),
		.done      (gen_done)
	);
	plb_prbs_chk #(
		.ERR_W (ERR_W)
	) u_chk (
		.mclk    (mclk),
		.rst     (rst),
		.stb     (nib_stb),
		.clr     (bist_clr),
		.cont    (stc_r[`PLB_STC_CONT]),
		.rx      (mac_rx_nxt),
		.locked  (chk_lock),
		.lost    (chk_lost),
		.err_cnt (err_cnt)
	);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_single_wr;
		wr_fire && hdr_r.adr == `PLB_ADR_STC && wdat[`PLB_STC_SINGLE]
			&& !single_r && !gen_busy;
	endsequence
	sequence s_rd_ta;
		mdc_rise && m_st_r == plb_pkg::PLB_M_TA && cnt_r == 4'h0 && rd_hit;
	endsequence

	a_loop_no_link: assert property ($rose(mii_lb) |=> !link_up_o)
		else $error("link reported during mac loopback");
	a_loop_echo: assert property (mii_lb && nib_stb && !bist_on
		|=> mac_rx_o == $past(mac_tx))
		else $error("mac loopback did not return transmit nibble");
	a_media_gate: assert property (mii_lb && !med_tx_ok && nib_stb
		|=> !pcs_tx_o.en)
		else $error("looped data reached line without enable");
	a_rev_echo: assert property (rev_lb && nib_stb
		|=> pcs_tx_o == $past(pcs_rx) && mac_rx_o == $past(pcs_rx))
		else $error("reverse loop did not echo line data");
	a_loop_prio: assert property ($onehot0(lb_pt_o)
		&& !(mii_lb && $past(mii_lb) && lb_pt_o != '0))
		else $error("more than one loop point selected");
	a_err_wrap: assert property (stc_r[`PLB_STC_CONT] && &err_cnt
		&& u_chk.inc_w && !bist_clr |=> err_cnt == '0)
		else $error("full error counter did not wrap");
	a_err_hold: assert property (!stc_r[`PLB_STC_CONT] && &err_cnt
		&& !bist_clr |=> &err_cnt)
		else $error("error counter moved past maximum in single mode");
	a_single_go: assert property (s_single_wr |-> ##[1:3] gen_busy)
		else $error("single packet did not start");
	a_rd_ta: assert property (s_rd_ta |=> !mdio_oe_n && !mdio_o)
		else $error("turnaround zero not driven on read");
	// bus release, request clear, loop priority and media copy
	a_rd_release: assert property (mdc_rise
		&& m_st_r == plb_pkg::PLB_M_DATA && cnt_r == `PLB_DATA_LAST
		|=> mdio_oe_n)
		else $error("mdio still driven after last data bit");
	a_single_clr: assert property (gen_done && !wr_fire |=> !single_r)
		else $error("single packet request not cleared when sent");
	a_pcs_in_prio: assert property (!mii_lb && stc_r[`PLB_STC_PCSI]
		|=> lb_pt_o.pcs_in)
		else $error("pcs input loop not chosen first");
	a_med_pass: assert property (mii_lb && med_tx_ok && nib_stb
		|=> pcs_tx_o == mac_rx_o)
		else $error("media copy differs from looped data");
endmodule // plb_loopback_bist

// ---- plb_mac_model.sv ----
// behavioural MAC that sends nibbles into the phy transmit path
`timescale 1ns/1ps
module plb_mac_model (
	input  wire logic         mclk,    // core clock
	input  wire logic         nib_stb, // one nibble time
	input  wire logic         send,    // frame in progress
	input  wire logic [3:0]   dat,     // next nibble to send
	output plb_pkg::plb_nib_t mac_tx   // nibble to the phy
);
	// drive just after the sampling edge; outside a frame the data toggles
	// so that stale data can never pass for a valid nibble
	always @(posedge mclk) begin
		if (nib_stb) begin
			mac_tx.en <= send;
			mac_tx.d  <= send ? dat : ~mac_tx.d;
		end
	end
	initial mac_tx = '0;
endmodule // plb_mac_model

// ---- plb_loopback_bist_test.sv ----
// self-checking bench: registers, loop points, datapath and prbs self-test
`timescale 1ns/1ps
module plb_loopback_bist_test;
	localparam int ERR_W = 4; // small counter so saturation is reachable
	logic              mclk, rst, mdc, tb_md, nib_stb, speed100, link_ok;
	logic              send, ext_lb, mdio_o, mdio_oe_n, link_up_o;
	logic [4:0]        phy_addr;
	logic [3:0]        dat, bad;
	logic [31:0]       rs;
	logic [14:0]       lf;
	logic [15:0]       q;
	logic [18:0]       st4;
	plb_pkg::plb_nib_t mac_tx, pcs_rx, mac_rx_o, pcs_tx_o, e_rx, e_tx;
	plb_pkg::plb_lpt_t lb_pt_o;
	int                miscompares, compares, on_len, off_len, hi_n, lo_n;
	int                mon;
	wire               mdio_w = mdio_oe_n ? tb_md : mdio_o; // pull-up idle

	plb_loopback_bist #(.ERR_W(ERR_W)) u_plb_loopback_bist (.mclk(mclk),
		.rst(rst), .mdc(mdc), .mdio_i(mdio_w), .mdio_o(mdio_o),
		.mdio_oe_n(mdio_oe_n), .phy_addr(phy_addr), .nib_stb(nib_stb),
		.speed100(speed100), .link_ok(link_ok), .mac_tx(mac_tx),
		.pcs_rx(pcs_rx), .mac_rx_o(mac_rx_o), .pcs_tx_o(pcs_tx_o),
		.lb_pt_o(lb_pt_o), .link_up_o(link_up_o));
	plb_mac_model u_plb_mac_model (.mclk(mclk), .nib_stb(nib_stb),
		.send(send), .dat(dat), .mac_tx(mac_tx));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// four steps of x^15+x^14+1, msb of the nibble first
	function automatic logic [18:0] nx(input logic [14:0] s);
		logic       b;
		logic [3:0] n;
		for (int i = 3; i >= 0; i--) begin
			b = s[14] ^ s[13];
			n[i] = b;
			s = {s[13:0], b};
		end
		return {s, n};
	endfunction
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one management frame; mdc phases of 4 clocks, read bits taken at rise
	task automatic mdio(input logic rd, input logic [4:0] ra,
		input logic [15:0] wd);
		logic [33:0] f;
		f = {4'b1101, rd ? 2'b10 : 2'b01, phy_addr, ra, 2'b10, wd};
		for (int i = 33; i >= 0; i--) begin
			tb_md = (rd && i < 18) ? 1'b1 : f[i];
			repeat (4) @(negedge mclk);
			mdc = 1'b1;
			q = (i < 16) ? {q[14:0], mdio_w} : q;
			repeat (4) @(negedge mclk);
			mdc = 1'b0;
		end
		tb_md = 1'b1;
		repeat (8) @(negedge mclk);
	endtask
	task automatic rdc(input logic [4:0] ra, input logic [15:0] e);
		mdio(1'b1, ra, 16'h0000);
		chk("register", e, q);
	endtask
	// mode 0 normal, 1 mac loop, 2 mac loop to media, 3 reverse, 4 at 10M
	task automatic dp(input int mode);
		logic st;
		st = 1'b0;
		speed100 = (mode != 4);
		repeat (200) begin
			@(negedge mclk);
			if (st) begin
				chk("mac_rx_o", {11'h0, e_rx}, {11'h0, mac_rx_o});
				chk("pcs_tx_o", {11'h0, e_tx}, {11'h0, pcs_tx_o});
			end
			chk("link_up_o", {15'h0, mode == 0 || mode == 3},
				{15'h0, link_up_o});
			rs = xs(rs);
			{pcs_rx, dat, send, nib_stb} = rs[10:0];
			st = nib_stb;
			e_rx = (mode == 0 || mode == 3) ? pcs_rx : mac_tx;
			e_tx = mode == 3 ? pcs_rx : (mode % 2 == 0 && mode != 4) ? mac_tx : '0;
		end
	endtask
	task automatic complete_run;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// line-side monitor: run lengths, generated data, cable loop with faults
	always @(negedge mclk) begin
		if (pcs_tx_o.en === 1'b1) begin
			lo_n = (off_len != 0) ? off_len : lo_n;
			off_len = 0;
			on_len++;
			st4 = nx(lf);
			if (mon == 1) chk("prbs", {12'h0, st4[3:0]}, {12'h0, pcs_tx_o.d});
			if (mon == 2) chk("fill", 16'h0005, {12'h0, pcs_tx_o.d});
			lf = st4[18:4];
		end else begin
			hi_n = (on_len != 0) ? on_len : hi_n;
			on_len = 0;
			off_len++;
		end
		if (ext_lb) pcs_rx = {pcs_tx_o.en, pcs_tx_o.d ^ bad};
	end
	// watchdog well beyond the expected run length of about 112 us
	initial begin
		#300us;
		miscompares++;
		$display("FAIL watchdog expected done seen hang");
		complete_run();
	end
	initial begin
		{mdc, nib_stb, send, dat, ext_lb, bad, mon, on_len, off_len} = '0;
		{tb_md, speed100, link_ok, rst} = 4'hF;
		rs = 32'd16651;
		phy_addr = rs[4:0] ^ 5'h0A;
		pcs_rx = '0;
		lf = 15'h7FFF;
		repeat (10) @(negedge mclk);
		rst = 1'b0;
		repeat (20) @(negedge mclk);
		rdc(5'h00, 16'h0000);
		rdc(5'h16, 16'h0000);
		rdc(5'h1B, 16'h0000);
		rdc(5'h1C, 16'h6040);
		rdc(5'h05, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			mdio(1'b0, 5'h16, 16'h0001 << i);
			rdc(5'h16, 16'h0001 << i);
			chk("lb_pt_o", 16'h0008 >> i, {12'h0, lb_pt_o});
		end
		mdio(1'b0, 5'h16, 16'h000F);
		chk("lb_pt_o", 16'h0008, {12'h0, lb_pt_o});
		mdio(1'b0, 5'h16, 16'h0000);
		chk("lb_pt_o", 16'h0000, {12'h0, lb_pt_o});
		dp(0);
		mdio(1'b0, 5'h00, 16'h4000);
		dp(1);
		mdio(1'b0, 5'h16, 16'h0040);
		dp(2);
		dp(4);
		mdio(1'b0, 5'h00, 16'h0000);
		mdio(1'b0, 5'h16, 16'h0010);
		dp(3);
		// prbs over a cable loop: short packets so lengths are visible
		mdio(1'b0, 5'h16, 16'h0000);
		{nib_stb, ext_lb, speed100, send} = 4'hE; // mac idle from here
		mdio(1'b0, 5'h1C, 16'h180A);
		lf = 15'h7FFF;
		mon = 1;
		mdio(1'b0, 5'h16, 16'hC000);
		repeat (300) @(negedge mclk);
		chk("packet", 16'd20, hi_n[15:0]);
		chk("gap", 16'd8, lo_n[15:0]);
		rdc(5'h16, 16'hCA00);
		rdc(5'h1B, 16'h0000);
		mon = 0;
		bad = 4'hF;
		rdc(5'h16, 16'hC600);
		bad = 4'h0;
		repeat (300) @(negedge mclk);
		rdc(5'h16, 16'hCA00);
		mdio(1'b1, 5'h1B, 16'h0000);
		chk("errors", 16'h0001, {15'h0, q != 16'h0000});
		// bursts of faults: continuous mode wraps the small counter,
		// single mode pins it at its top; short bursts keep the lock
		for (int m = 0; m < 2; m++) begin
			if (m == 1) begin
				mdio(1'b0, 5'h16, 16'h0000);
				mdio(1'b0, 5'h16, 16'h8000);
				rdc(5'h1B, 16'h0000);
			end
			repeat (30) begin
				bad = 4'hF;
				repeat (6) @(negedge mclk);
				bad = 4'h0;
				repeat (60) @(negedge mclk);
			end
			if (m == 0) rdc(5'h16, 16'hCA00);
		end
		rdc(5'h1B, 16'h000F);
		// constant packets, short then long
		mdio(1'b0, 5'h16, 16'h0000);
		repeat (100) @(negedge mclk);
		mon = 2;
		for (int l = 0; l < 2; l++) begin
			mdio(1'b0, 5'h16, 16'h2000 | (l << 12));
			repeat (3200) @(negedge mclk);
			chk("const_len", l ? 16'd3036 : 16'd128, hi_n[15:0]);
			// fill data is no prbs, so the looped checker shows sync lost
			rdc(5'h16, 16'h0400 | (l << 12));
		end
		complete_run();
	end
endmodule // plb_loopback_bist_test
